// file: iab_chk.sv
// Port-level assertions of the indirect access and bridge control bank
module iab_chk #(
    parameter int ADDR_W = 12
) (
    input wire logic              SYS_CLK_I,
    input wire logic              ARST_N_I,
    input wire logic              CLK_EN_I,
    input wire logic              PSEL_I,
    input wire logic              PENABLE_I,
    input wire logic              PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [31:0]       PWDATA_I,
    input wire logic [31:0]       PRDATA_O,
    input wire logic              PREADY_O,
    input wire logic              PSLVERR_O,
    input wire logic [7:0]        TGT_RDATA_I,
    input wire iab_pkg::iab_tgt_s TGT_O,
    input wire logic              MODE_STRAP_ONE_I,
    input wire logic [1:0]        LANE_STRAP_I,
    input wire logic              RELOAD_DONE_I,
    input wire iab_pkg::iab_brg_s BRG_O
);
    // ************************************************************
    // Transfer decode and control shadows
    // ************************************************************
    logic wr_done, rd_done, rm_q, au_q, on;
    logic a_ctl, a_ofs, a_val, a_br;
    assign wr_done = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;
    assign rd_done = PSEL_I & PENABLE_I & PREADY_O & ~PWRITE_I;
    assign a_ctl   = PADDR_I == ADDR_W'({iab_pkg::IDX_IND_CTL, 2'h0});
    assign a_ofs   = PADDR_I == ADDR_W'({iab_pkg::IDX_IND_OFS, 2'h0});
    assign a_val   = PADDR_I == ADDR_W'({iab_pkg::IDX_IND_VAL, 2'h0});
    assign a_br    = PADDR_I == ADDR_W'({iab_pkg::IDX_BRIDGE, 2'h0});
    assign on      = TGT_O.page != iab_pkg::PAGE_OFF;
    // Shadows follow what software last wrote, so they assume the clock enable stays high
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rm_q <= 1'b0;
            au_q <= 1'b0;
        end else if (wr_done && a_ctl) begin
            rm_q <= PWDATA_I[0];
            au_q <= PWDATA_I[1];
        end
    end
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    wait_state_a: assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
        else $error("ready missing after one wait state");
    wr_strobe_a: assert property (wr_done && a_val && on |=> TGT_O.wr
        && TGT_O.wdata == $past(PWDATA_I[7:0])) else $error("indirect write not issued");
    off_quiet_a: assert property (!on |-> !(TGT_O.wr || TGT_O.rd || TGT_O.clr))
        else $error("strobe on disabled page");
    off_zero_a: assert property (rd_done && a_val && !on |-> PRDATA_O == 32'h0)
        else $error("disabled page read not zero");
    ofs_prefetch_a: assert property (wr_done && a_ofs && rm_q && on |=> TGT_O.rd
        && TGT_O.addr == $past(PWDATA_I[7:0])) else $error("no prefetch strobe");
    clear_gate_a: assert property (TGT_O.clr |-> rm_q && $past(rd_done))
        else $error("clear without read mode read");
    auto_step_a: assert property (rd_done && a_val && rm_q && au_q && on |=> TGT_O.rd
        && TGT_O.addr == $past(TGT_O.addr) + 8'h01) else $error("auto step read wrong");
    reload_set_a: assert property (wr_done && a_br && PWDATA_I[1] |=> BRG_O.reload)
        else $error("reload not started");
    reload_end_a: assert property ($rose(RELOAD_DONE_I) && BRG_O.reload
        |-> ##[1:8] !BRG_O.reload) else $error("reload bit not cleared");
    swap_src_a: assert property (BRG_O.swap |-> $past(BRG_O.choice))
        else $error("swap without port choice");
endmodule // iab_chk

bind iab_top iab_chk #(.ADDR_W(ADDR_W)) u_chk (.SYS_CLK_I(SYS_CLK_I), .ARST_N_I(ARST_N_I),
    .CLK_EN_I(CLK_EN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
    .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .TGT_RDATA_I(TGT_RDATA_I), .TGT_O(TGT_O),
    .MODE_STRAP_ONE_I(MODE_STRAP_ONE_I), .LANE_STRAP_I(LANE_STRAP_I),
    .RELOAD_DONE_I(RELOAD_DONE_I), .BRG_O(BRG_O));

// file: iab_pkg.sv
// Constants, field layout and carrier types of the indirect access and bridge control bank
package iab_pkg;

    // ************************************************************
    // Register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [7:0] IDX_IND_CTL  = 8'h40;
    localparam logic [7:0] IDX_IND_OFS  = 8'h41;
    localparam logic [7:0] IDX_IND_VAL  = 8'h42;
    localparam logic [7:0] IDX_BRIDGE   = 8'h4f;
    localparam logic [7:0] IDX_PORT_ACC = 8'h50;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CTL_RD_MODE  = 0;
    localparam int CTL_AUTO     = 1;
    localparam int CTL_PAGE_LO  = 2;
    localparam int CTL_PAGE_HI  = 4;
    localparam int BR_RELOAD    = 1;
    localparam int BR_LANE_LO   = 2;
    localparam int BR_LANE_HI   = 3;
    localparam int BR_STEREO    = 4;
    localparam int BR_CHOICE    = 5;
    localparam int BR_TWO_IN    = 6;
    localparam int BR_CLK_HS    = 7;
    localparam int PA_SEL       = 0;
    localparam int PA_INDEP     = 1;

    // ************************************************************
    // Encodings, reset values and counts
    // ************************************************************
    localparam logic [2:0] PAGE_OFF    = 3'h0;
    localparam logic [2:0] PAGE_RX0    = 3'h1;
    localparam logic [2:0] PAGE_RX1    = 3'h2;
    localparam logic [7:0] BYTE_RST    = 8'h00;
    localparam logic [7:0] OFS_STEP    = 8'h01;
    localparam logic [1:0] STRAP_WAIT  = 2'h2;
    localparam logic [23:0] RD_PAD     = 24'h000000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RESP = 2'b01
    } iab_apb_e;

    // Indirect target port
    typedef struct packed {
        logic [2:0] page;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
        logic       clr;
    } iab_tgt_s;

    // Bridge controls toward the receiver and video path
    typedef struct packed {
        logic [1:0] clk_hs;
        logic       two_in;
        logic       choice;
        logic       swap;
        logic       stereo;
        logic [1:0] lanes;
        logic       reload;
    } iab_brg_s;

endpackage

// file: iab_tb.sv
// Self-checking bench of the indirect access and bridge control bank
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] A_CTL = {2'h0, iab_pkg::IDX_IND_CTL, 2'h0};
    localparam logic [11:0] A_OFS = {2'h0, iab_pkg::IDX_IND_OFS, 2'h0};
    localparam logic [11:0] A_VAL = {2'h0, iab_pkg::IDX_IND_VAL, 2'h0};
    localparam logic [11:0] A_BR  = {2'h0, iab_pkg::IDX_BRIDGE, 2'h0};
    localparam logic [11:0] A_PA  = {2'h0, iab_pkg::IDX_PORT_ACC, 2'h0};
    logic              clk, arst_n, psel, pen, pwr, pready, pslverr, strap, rdone, err, ce;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, q;
    logic [7:0]        trd;
    logic [1:0]        lstrap;
    iab_pkg::iab_tgt_s tgt;
    iab_pkg::iab_brg_s brg;
    int                bad_count = 0, n_checks = 0, cyc = 0, n_wr = 0, n_rd = 0, n_clr = 0;
    iab_top DUT (.SYS_CLK_I(clk), .ARST_N_I(arst_n), .CLK_EN_I(ce), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .TGT_RDATA_I(trd),
        .TGT_O(tgt), .MODE_STRAP_ONE_I(strap), .LANE_STRAP_I(lstrap),
        .RELOAD_DONE_I(rdone), .BRG_O(brg));
    always #2 clk = ~clk;
    // ************************************************************
    // Strobe counters, timeout and verdict
    // ************************************************************
    always @(posedge clk) begin
        cyc++;
        if (tgt.wr === 1'b1) n_wr++;
        if (tgt.rd === 1'b1) n_rd++;
        if (tgt.clr === 1'b1) n_clr++;
        if (cyc == 3000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Holds the request until ready is seen high; a hang is cut by the timeout
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic t_reset();
        apb(0, A_OFS, 8'h0);
        `CHK("ofs reset", 32'h0, q)
        apb(0, A_VAL, 8'h0);
        `CHK("off read", 32'h0, q)
        apb(0, A_BR, 8'h0);
        `CHK("bridge reset", 32'h88, q)
        `CHK("clk hs strap", 2'b11, brg.clk_hs)
        apb(0, 12'h1fc, 8'h0);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0, q)
    endtask
    task automatic t_window();
        apb(1, A_OFS, 8'ha5);
        apb(0, A_OFS, 8'h0);
        `CHK("ofs rw", 32'ha5, q)
        apb(1, A_VAL, 8'h11);
        tick(2);
        `CHK("off write", 0, n_wr)
        apb(1, A_CTL, {3'h0, iab_pkg::PAGE_RX0, 2'b00});
        apb(1, A_OFS, 8'h10);
        tick(2);
        `CHK("no prefetch", 0, n_rd)
        apb(1, A_VAL, 8'h3c);
        tick(2);
        `CHK("wr count", 1, n_wr)
        `CHK("wr data", 8'h3c, tgt.wdata)
        `CHK("wr addr", 8'h10, tgt.addr)
        trd <= 8'h5a;
        apb(0, A_VAL, 8'h0);
        tick(2);
        `CHK("rd value", 32'h5a, q)
        `CHK("no clear", 0, n_clr)
        apb(1, A_CTL, {3'h0, iab_pkg::PAGE_RX1, 2'b01});
        apb(0, A_VAL, 8'h0);
        tick(2);
        `CHK("clear", 1, n_clr)
        `CHK("page", iab_pkg::PAGE_RX1, tgt.page)
        apb(1, A_OFS, 8'h20);
        tick(2);
        `CHK("prefetch", 1, n_rd)
        apb(1, A_CTL, {3'h0, iab_pkg::PAGE_RX0, 2'b11});
        apb(0, A_VAL, 8'h0);
        tick(2);
        `CHK("rd step", 8'h21, tgt.addr)
        `CHK("rd strobe", 2, n_rd)
        apb(1, A_CTL, {3'h0, iab_pkg::PAGE_RX0, 2'b10});
        apb(1, A_VAL, 8'h77);
        apb(0, A_VAL, 8'h0);
        tick(2);
        `CHK("wr step only", 8'h22, tgt.addr)
        apb(1, A_CTL, {3'h0, 3'h5, 2'b01});
        apb(0, A_VAL, 8'h0);
        tick(2);
        `CHK("reserved clear", 2, n_clr)
    endtask
    task automatic t_bridge();
        apb(1, A_BR, 8'h54);
        tick(2);
        `CHK("two in", 1'b1, brg.two_in)
        `CHK("choice low", 1'b0, brg.choice)
        `CHK("stereo", 1'b1, brg.stereo)
        `CHK("lanes", 2'b01, brg.lanes)
        `CHK("clk hs off", 2'b00, brg.clk_hs)
        apb(0, A_BR, 8'h0);
        `CHK("bridge rw", 32'h54, q)
        apb(1, A_PA, 8'h02);
        apb(1, A_BR, 8'h20);
        tick(2);
        `CHK("choice", 1'b1, brg.choice)
        `CHK("swap", 1'b1, brg.swap)
        apb(1, A_BR, 8'h80);
        tick(2);
        `CHK("clk hs port", 2'b01, brg.clk_hs)
        `CHK("unswap", 1'b0, brg.swap)
        apb(1, A_PA, 8'h03);
        apb(0, A_BR, 8'h0);
        `CHK("clk hs other", 1'b0, q[7])
        apb(1, A_PA, 8'h00);
    endtask
    task automatic t_reload();
        apb(1, A_BR, 8'h02);
        tick(2);
        `CHK("reload set", 1'b1, brg.reload)
        ce <= 1'b0;
        rdone <= 1'b1;
        tick(4);
        `CHK("frozen reload", 1'b1, brg.reload)
        ce <= 1'b1;
        while (brg.reload === 1'b1) @(posedge clk);
        tick(1);
        `CHK("clk hs back", 2'b11, brg.clk_hs)
        `CHK("lanes back", 2'b10, brg.lanes)
        apb(0, A_BR, 8'h0);
        `CHK("reload done", 1'b0, q[1])
        rdone <= 1'b0;
    endtask
    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        {psel, pen, pwr, rdone} = 4'h0;
        ce = 1'b1;
        paddr = 12'h0;
        pwdata = 32'h0;
        trd = 8'h00;
        strap = 1'b1;
        lstrap = 2'b10;
        tick(12);
        arst_n <= 1'b1;
        tick(8);
        t_reset();
        t_window();
        t_bridge();
        t_reload();
        conclude();
    end
endmodule // tb

// file: iab_top.sv
// Indirect access window and bridge control registers behind an APB slave
// Summary of operation
// - Receiver status clears on read only while read mode is set.
// - Offset write with read mode set sends one read strobe to target.
// - Auto-increment with read mode: read strobe after each value read.
// - Offset register is 8-bit read/write, resets to zero.
// - Writing value register writes that byte to the selected target register.
// - Reading value register returns the selected target register contents.
// - Clock lane bit one means continuous high-speed clock, skip lane init.
// - Clock lane bit resets from the mode strap pin.
// - Independent mode keeps one clock lane bit per serial output port.
// - Two input bit selects dual or single input mode, resets zero.
// - Single input mode: port choice picks input port 0 or 1.
// - Independent mode: port choice one swaps input to output routing.
// - Stereo bit merges alternating line images into alternating pixels.
// - Lane count field selects one to four lanes, resets from strap.
// - Reload bit reloads configuration and restores strapped settings.
// - Reload bit clears itself when the reload has completed.
// - Page code 000 disabled, 001 receiver 0, 010 receiver 1, others reserved.
// - Auto-increment steps offset after access; reads only with read mode.
module iab_top #(
    parameter int ADDR_W = 12
) (
    input  wire logic              SYS_CLK_I,
    input  wire logic              ARST_N_I,
    input  wire logic              CLK_EN_I,
    input  wire logic              PSEL_I,
    input  wire logic              PENABLE_I,
    input  wire logic              PWRITE_I,
    input  wire logic [ADDR_W-1:0] PADDR_I,
    input  wire logic [31:0]       PWDATA_I,
    output logic      [31:0]       PRDATA_O,
    output logic                   PREADY_O,
    output logic                   PSLVERR_O,
    input  wire logic [7:0]        TGT_RDATA_I,
    output iab_pkg::iab_tgt_s      TGT_O,
    input  wire logic              MODE_STRAP_ONE_I,
    input  wire logic [1:0]        LANE_STRAP_I,
    input  wire logic              RELOAD_DONE_I,
    output iab_pkg::iab_brg_s      BRG_O
);

    // ************************************************************
    // Byte address of a register index
    // ************************************************************
    function automatic logic [ADDR_W-1:0] badr(input logic [7:0] idx);
        badr = ADDR_W'({idx, 2'b00});
    endfunction

    // ************************************************************
    // Reset release and pin synchronisers
    // ************************************************************
    logic [1:0]         rst_s_q;
    logic               rst_n;
    logic [3:0]         pin_s1_q;
    logic [3:0]         pin_s2_q;
    logic               done_d1_q;
    logic [1:0]         strap_cnt_q;
    logic               strap_ok_q;

    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rst_s_q <= 2'h0;
        end else if (CLK_EN_I) begin
            rst_s_q <= {rst_s_q[0], 1'b1};
        end
    end

    assign rst_n = rst_s_q[1];

    // Straps and the done pin come from outside the clock domain
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q  <= 4'h0;
            pin_s2_q  <= 4'h0;
            done_d1_q <= 1'b0;
        end else if (CLK_EN_I) begin
            pin_s1_q  <= {RELOAD_DONE_I, LANE_STRAP_I, MODE_STRAP_ONE_I};
            pin_s2_q  <= pin_s1_q;
            done_d1_q <= pin_s2_q[3];
        end
    end

    logic               strap_hs;
    logic [1:0]         strap_lanes;
    logic               done_rise;
    logic               strap_go;

    assign strap_hs    = pin_s2_q[0];
    assign strap_lanes = pin_s2_q[2:1];
    assign done_rise   = pin_s2_q[3] & ~done_d1_q;
    // Straps are caught once the synchronisers hold settled pin values
    assign strap_go    = (strap_cnt_q == iab_pkg::STRAP_WAIT) & ~strap_ok_q;

    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt_q <= 2'h0;
            strap_ok_q  <= 1'b0;
        end else if (CLK_EN_I) begin
            if (strap_cnt_q != iab_pkg::STRAP_WAIT) begin
                strap_cnt_q <= strap_cnt_q + 2'h1;
            end
            if (strap_go) begin
                strap_ok_q <= 1'b1;
            end
        end
    end

    // ************************************************************
    // APB access sequencing
    // ************************************************************
    iab_pkg::iab_apb_e  state_q;
    iab_pkg::iab_apb_e  state_d;
    logic               acc;
    logic               commit;
    logic               wr_c;
    logic               rd_c;

    assign acc     = PSEL_I & PENABLE_I;
    // One wait state: read data is sampled before any side effect fires
    assign state_d = (state_q == iab_pkg::ST_IDLE && acc) ? iab_pkg::ST_RESP
                                                          : iab_pkg::ST_IDLE;
    assign commit  = acc & (state_q == iab_pkg::ST_RESP);
    assign wr_c    = commit & PWRITE_I;
    assign rd_c    = commit & ~PWRITE_I;

    // ************************************************************
    // Address decode
    // ************************************************************
    logic               hit_ctl;
    logic               hit_ofs;
    logic               hit_val;
    logic               hit_brg;
    logic               hit_pa;
    logic               hit_any;

    assign hit_ctl = PADDR_I == badr(iab_pkg::IDX_IND_CTL);
    assign hit_ofs = PADDR_I == badr(iab_pkg::IDX_IND_OFS);
    assign hit_val = PADDR_I == badr(iab_pkg::IDX_IND_VAL);
    assign hit_brg = PADDR_I == badr(iab_pkg::IDX_BRIDGE);
    assign hit_pa  = PADDR_I == badr(iab_pkg::IDX_PORT_ACC);
    assign hit_any = hit_ctl | hit_ofs | hit_val | hit_brg | hit_pa;

    // ************************************************************
    // Indirect window state
    // ************************************************************
    logic [2:0]         page_q;
    logic [7:0]         ofs_q;
    logic [7:0]         wdata_q;
    logic               wr_q;
    logic               rd_q;
    logic               clr_q;
    logic               rd_mode_q;
    logic               auto_q;
    logic               ctl_wr;
    logic               ofs_wr;
    logic               page_on;
    logic               page_dig;
    logic               val_wr;
    logic               val_rd;
    logic               step;

    assign ctl_wr   = wr_c & hit_ctl;
    assign ofs_wr   = wr_c & hit_ofs;
    assign page_on  = page_q != iab_pkg::PAGE_OFF;
    assign page_dig = (page_q == iab_pkg::PAGE_RX0) |
                      (page_q == iab_pkg::PAGE_RX1);
    assign val_wr   = wr_c & hit_val & page_on;
    assign val_rd   = rd_c & hit_val & page_on;
    // Reads step only in read mode so a peek does not move the window
    assign step     = auto_q & (val_wr | (val_rd & rd_mode_q));

    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            rd_mode_q <= 1'b0;
            auto_q    <= 1'b0;
            page_q    <= iab_pkg::PAGE_OFF;
        end else if (CLK_EN_I && ctl_wr) begin
            rd_mode_q <= PWDATA_I[iab_pkg::CTL_RD_MODE];
            auto_q    <= PWDATA_I[iab_pkg::CTL_AUTO];
            page_q    <= PWDATA_I[iab_pkg::CTL_PAGE_HI:iab_pkg::CTL_PAGE_LO];
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            ofs_q <= iab_pkg::BYTE_RST;
        end else if (CLK_EN_I) begin
            if (ofs_wr) begin
                ofs_q <= PWDATA_I[7:0];
            end else if (step) begin
                ofs_q <= ofs_q + iab_pkg::OFS_STEP;
            end
        end
    end

    // ************************************************************
    // Indirect target strobes
    // ************************************************************
    logic               rd_strobe;
    logic               clr_strobe;

    assign rd_strobe  = page_on & rd_mode_q & (ofs_wr | (val_rd & auto_q));
    // The clear trails the read by a cycle, after any auto-step, so a
    // target that clears exactly must latch its offset when it is read
    assign clr_strobe = val_rd & rd_mode_q & page_dig;

    // Strobes come out with the offset already stepped; only the read strobe refers to that offset
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            wdata_q <= iab_pkg::BYTE_RST;
            wr_q    <= 1'b0;
            rd_q    <= 1'b0;
            clr_q   <= 1'b0;
        end else if (CLK_EN_I) begin
            if (val_wr) begin
                wdata_q <= PWDATA_I[7:0];
            end
            wr_q  <= val_wr;
            rd_q  <= rd_strobe;
            clr_q <= clr_strobe;
        end
    end

    assign TGT_O = '{page:  page_q,
                     addr:  ofs_q,
                     wdata: wdata_q,
                     wr:    wr_q,
                     rd:    rd_q,
                     clr:   clr_q};

    // ************************************************************
    // Bridge control state
    // ************************************************************
    logic [1:0]         clk_hs_q;
    logic               two_in_q;
    logic               choice_q;
    logic               stereo_q;
    logic [1:0]         lanes_q;
    logic               reload_q;
    logic               pa_sel_q;
    logic               pa_indep_q;
    logic               swap_q;
    logic               restore;
    logic               brg_wr;
    logic               reload_set;
    logic               pa_wr;

    assign restore    = strap_go | done_rise;
    assign brg_wr     = wr_c & hit_brg;
    assign reload_set = brg_wr & PWDATA_I[iab_pkg::BR_RELOAD];
    assign pa_wr      = wr_c & hit_pa;

    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            pa_sel_q   <= 1'b0;
            pa_indep_q <= 1'b0;
        end else if (CLK_EN_I && pa_wr) begin
            pa_sel_q   <= PWDATA_I[iab_pkg::PA_SEL];
            pa_indep_q <= PWDATA_I[iab_pkg::PA_INDEP];
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            two_in_q <= 1'b0;
            choice_q <= 1'b0;
            stereo_q <= 1'b0;
        end else if (CLK_EN_I && brg_wr) begin
            two_in_q <= PWDATA_I[iab_pkg::BR_TWO_IN];
            choice_q <= PWDATA_I[iab_pkg::BR_CHOICE];
            stereo_q <= PWDATA_I[iab_pkg::BR_STEREO];
        end
    end

    // Strap restore wins over a software write in the same cycle
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            clk_hs_q <= 2'h0;
            lanes_q  <= 2'h0;
        end else if (CLK_EN_I) begin
            if (restore) begin
                clk_hs_q <= {strap_hs, strap_hs};
                lanes_q  <= strap_lanes;
            end else if (brg_wr) begin
                lanes_q <= PWDATA_I[iab_pkg::BR_LANE_HI:iab_pkg::BR_LANE_LO];
                if (pa_indep_q) begin
                    clk_hs_q[pa_sel_q] <= PWDATA_I[iab_pkg::BR_CLK_HS];
                end else begin
                    clk_hs_q <= {2{PWDATA_I[iab_pkg::BR_CLK_HS]}};
                end
            end
        end
    end

    // A new request in the completion cycle keeps the bit set
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            reload_q <= 1'b0;
        end else if (CLK_EN_I) begin
            if (reload_set) begin
                reload_q <= 1'b1;
            end else if (done_rise) begin
                reload_q <= 1'b0;
            end
        end
    end

    // Swap only means something in independent two by two operation
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            swap_q <= 1'b0;
        end else if (CLK_EN_I) begin
            swap_q <= pa_indep_q & choice_q;
        end
    end

    assign BRG_O = '{clk_hs: clk_hs_q,
                     two_in: two_in_q,
                     choice: choice_q,
                     swap:   swap_q,
                     stereo: stereo_q,
                     lanes:  lanes_q,
                     reload: reload_q};

    // ************************************************************
    // Read data selection
    // ************************************************************
    logic [7:0]         ctl_rd;
    logic [7:0]         brg_rd;
    logic [7:0]         pa_rd;
    logic [7:0]         rdata_w;

    assign ctl_rd = {3'h0, page_q, auto_q, rd_mode_q};
    assign brg_rd = {clk_hs_q[pa_sel_q], two_in_q, choice_q, stereo_q,
                     lanes_q, reload_q, 1'b0};
    assign pa_rd  = {6'h00, pa_indep_q, pa_sel_q};

    assign rdata_w = hit_ctl ? ctl_rd :
                     hit_ofs ? ofs_q :
                     hit_val ? (page_on ? TGT_RDATA_I : iab_pkg::BYTE_RST) :
                     hit_brg ? brg_rd :
                     hit_pa  ? pa_rd :
                               iab_pkg::BYTE_RST;

    // ************************************************************
    // APB answer registers
    // ************************************************************
    logic               resp_d;

    assign resp_d = state_d == iab_pkg::ST_RESP;

    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= iab_pkg::ST_IDLE;
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O  <= 32'h00000000;
        end else if (CLK_EN_I) begin
            state_q   <= state_d;
            PREADY_O  <= resp_d;
            PSLVERR_O <= resp_d & ~hit_any;
            if (resp_d && !PWRITE_I) begin
                PRDATA_O <= {iab_pkg::RD_PAD, rdata_w};
            end else begin
                PRDATA_O <= 32'h00000000;
            end
        end
    end

endmodule // iab_top
